//--- switch_node_config_regs.sv
// Switch node configuration bank: clock multiplier settings, dividers,
// identity words, routing tables, debug origin and per-link registers.
// Assumes one-cycle config strobes from the tiles and router status inputs.
`timescale 1ns/100ps
module switch_node_config_regs
  import node_cfg_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Configuration access
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  output logic CFG_ACK,
  // One-time-programmable user code
  input wire logic [13:0] OTP_USER_CODE,
  // Debug events
  input wire logic DEBUG_EVENT_TILE0,
  input wire logic DEBUG_EVENT_TILE1,
  // Router status per link
  input wire node_cfg_pkg::link_state_type [NUM_LINKS-1:0] LINK_STATE,
  // Routing lookup
  input wire logic [15:0] DEST_ID,
  output logic [3:0] ROUTE_DIRECTION,
  output logic ROUTE_MISMATCH,
  // Clock multiplier control
  output node_cfg_pkg::mult_cfg_type MULT_CFG,
  output logic TILE_RESET,
  // Derived clock enables
  output logic SWITCH_CLK_EN,
  output logic REF_CLK_EN,
  // Link settings
  output logic [NUM_LINKS*4-1:0] LINK_DIRECTION,
  output logic [NUM_LINKS*2-1:0] LINK_NETWORK
);
  import node_cfg_pkg::*;

  // ************************************************************
  // Storage
  // ************************************************************
  logic [31:0] switch_config_ff;
  logic [15:0] node_id_ff;
  // Whole settings word kept, reserved bits forced to zero on write
  logic [31:0] clock_mult_ff;
  logic [15:0] switch_div_ff;
  logic [15:0] ref_div_ff;
  logic [31:0] route_low_ff;
  logic [31:0] route_high_ff;
  logic [1:0] reserved_a_ff;
  logic [1:0] reserved_b_ff;
  logic [4:0] debug_origin_ff;
  // Eight words only, so plain registers rather than a memory
  logic [3:0] link_dir_ff [NUM_LINKS];
  logic [1:0] link_net_ff [NUM_LINKS];
  logic [31:0] nxt_rdata;
  logic [3:0] nxt_direction;
  logic nxt_mismatch;
  logic sw_tick;
  logic ref_tick;

  // Eight link registers; the ninth printed number stays unmapped
  function automatic logic is_link(input logic [7:0] addr);
    return addr >= LINK_BASE_OFS && addr < LINK_BASE_OFS + 8'(NUM_LINKS);
  endfunction : is_link

  function automatic logic [2:0] link_index(input logic [7:0] addr);
    return 3'(addr - LINK_BASE_OFS);
  endfunction : link_index

  wire logic wr_mult = CFG_WR && CFG_ADDR == CLOCK_MULT_OFS;

  // ************************************************************
  // Switch configuration and node identifier
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      switch_config_ff <= 32'h0000_0000;
    end else if (CFG_WR && CFG_ADDR == SWITCH_CONFIG_OFS) begin
      // reserved bits dropped
      // Header mode is kept for readback only; the register lock (bit 8) blocks clock multiplier writes
      switch_config_ff <= CFG_WDATA & SW_CFG_MASK;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      node_id_ff <= 16'h0000;
    end else if (CFG_WR && CFG_ADDR == NODE_ID_OFS) begin
      // node identifier
      // Upper half is reserved and never stored
      node_id_ff <= CFG_WDATA[15:0];
    end
  end

  // ************************************************************
  // Clock multiplier settings
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      clock_mult_ff <= CLOCK_MULT_RST;
    // write lock honoured
    // A locked write raises no tile reset either
    end else if (wr_mult && !switch_config_ff[SW_CFG_MULT_LOCK_BIT]) begin
      clock_mult_ff <= CFG_WDATA & CM_WRITE_MASK;
    end
  end

  // tile reset pulse, suppressed by bit 31
  // One-cycle pulse; the reset sequencer stretches it as it needs
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      TILE_RESET <= 1'b0;
    end else begin
      TILE_RESET <= wr_mult && !switch_config_ff[SW_CFG_MULT_LOCK_BIT]
                    && !CFG_WDATA[CM_NO_RESET_BIT];
    end
  end

  // mode bits; fields carried as ratio minus one
  // Registered copy keeps the multiplier inputs glitch free
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      MULT_CFG <= '0;
    end else begin
      MULT_CFG.no_wait <= clock_mult_ff[CM_NO_WAIT_BIT];
      MULT_CFG.bypass <= clock_mult_ff[CM_BYPASS_BIT];
      MULT_CFG.jtag_boot <= clock_mult_ff[CM_JTAG_BOOT_BIT];
      MULT_CFG.p_div <= clock_mult_ff[25:23];
      MULT_CFG.m_mul <= clock_mult_ff[20:8];
      MULT_CFG.n_div <= clock_mult_ff[6:0];
    end
  end

  // ************************************************************
  // Switch and reference dividers
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      switch_div_ff <= SWITCH_CLK_DIV_RST;
      ref_div_ff <= REF_CLK_DIV_RST;
    end else if (CFG_WR && CFG_ADDR == SWITCH_CLK_DIV_OFS) begin
      switch_div_ff <= CFG_WDATA[15:0];
    end else if (CFG_WR && CFG_ADDR == REF_CLK_DIV_OFS) begin
      ref_div_ff <= CFG_WDATA[15:0];
    end
  end

  // Lowering a ratio below the running count wraps at once: one short period
  // switch clock enable
  clock_divider u_switch_div (
    .clk(MCLK),
    .rst_n(RST_N),
    .ratio(switch_div_ff),
    .tick(sw_tick)
  );

  clock_divider u_ref_div (
    .clk(MCLK),
    .rst_n(RST_N),
    .ratio(ref_div_ff),
    .tick(ref_tick)
  );

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      SWITCH_CLK_EN <= 1'b0;
      REF_CLK_EN <= 1'b0;
    end else begin
      SWITCH_CLK_EN <= sw_tick;
      REF_CLK_EN <= ref_tick;
    end
  end

  // ************************************************************
  // Routing tables
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      route_low_ff <= 32'h0000_0000;
      route_high_ff <= 32'h0000_0000;
    end else if (CFG_WR && CFG_ADDR == ROUTE_LOW_OFS) begin
      route_low_ff <= CFG_WDATA;
    end else if (CFG_WR && CFG_ADDR == ROUTE_HIGH_OFS) begin
      route_high_ff <= CFG_WDATA;
    end
  end

  // route lookup
  // Registered answer lags DEST_ID by one cycle; lookup stays off the pins
  route_select u_route (
    .directions({route_high_ff, route_low_ff}),
    .node_id(node_id_ff),
    .dest_id(DEST_ID),
    .direction(nxt_direction),
    .mismatch(nxt_mismatch)
  );

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ROUTE_DIRECTION <= 4'h0;
      ROUTE_MISMATCH <= 1'b0;
    end else begin
      ROUTE_DIRECTION <= nxt_direction;
      ROUTE_MISMATCH <= nxt_mismatch;
    end
  end

  // ************************************************************
  // Reserved scratch bits and debug origin
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      reserved_a_ff <= 2'b00;
      reserved_b_ff <= 2'b00;
    end else if (CFG_WR && CFG_ADDR == RESERVED_A_OFS) begin
      reserved_a_ff <= CFG_WDATA[1:0];
    end else if (CFG_WR && CFG_ADDR == RESERVED_B_OFS) begin
      reserved_b_ff <= CFG_WDATA[1:0];
    end
  end

  // latest event wins; an event beats a software write
  // Bit 4 is scratch and survives events; tile bits are replaced as a pair
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      debug_origin_ff <= 5'h00;
    end else if (DEBUG_EVENT_TILE0 || DEBUG_EVENT_TILE1) begin
      debug_origin_ff <= {debug_origin_ff[4], 2'b00, DEBUG_EVENT_TILE1, DEBUG_EVENT_TILE0};
    end else if (CFG_WR && CFG_ADDR == DEBUG_ORIGIN_OFS) begin
      debug_origin_ff <= 5'(CFG_WDATA & DEBUG_MASK);
    end
  end

  // ************************************************************
  // Per-link settings
  // ************************************************************
  // one register per link
  // Only direction and network are stored; status comes live from the router
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_LINKS; i++) begin
        link_dir_ff[i] <= 4'h0;
        link_net_ff[i] <= 2'b00;
      end
    end else if (CFG_WR && is_link(CFG_ADDR)) begin
      link_dir_ff[link_index(CFG_ADDR)] <= CFG_WDATA[11:8];
      link_net_ff[link_index(CFG_ADDR)] <= CFG_WDATA[5:4];
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      LINK_DIRECTION <= '0;
      LINK_NETWORK <= '0;
    end else begin
      for (int i = 0; i < NUM_LINKS; i++) begin
        LINK_DIRECTION[4 * i +: 4] <= link_dir_ff[i];
        LINK_NETWORK[2 * i +: 2] <= link_net_ff[i];
      end
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // Decoded from the live address; taken only on a read strobe
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (is_link(CFG_ADDR)) begin
      nxt_rdata[25:24] = LINK_STATE[link_index(CFG_ADDR)].attached_target_kind;
      nxt_rdata[23:16] = LINK_STATE[link_index(CFG_ADDR)].dest_link;
      nxt_rdata[11:8] = link_dir_ff[link_index(CFG_ADDR)];
      nxt_rdata[5:4] = link_net_ff[link_index(CFG_ADDR)];
      nxt_rdata[2] = LINK_STATE[link_index(CFG_ADDR)].junk;
      nxt_rdata[1] = LINK_STATE[link_index(CFG_ADDR)].dest_busy;
      nxt_rdata[0] = LINK_STATE[link_index(CFG_ADDR)].src_busy;
    end else begin
      unique case (CFG_ADDR)
        SWITCH_CONFIG_OFS: nxt_rdata = switch_config_ff;
        NODE_ID_OFS: nxt_rdata = {16'h0000, node_id_ff};
        CLOCK_MULT_OFS: nxt_rdata = clock_mult_ff;
        SWITCH_CLK_DIV_OFS: nxt_rdata = {16'h0000, switch_div_ff};
        REF_CLK_DIV_OFS: nxt_rdata = {16'h0000, ref_div_ff};
        SCAN_IDENTITY_OFS: nxt_rdata = SCAN_IDENTITY_VAL;
        USER_CODE_OFS: nxt_rdata = {OTP_USER_CODE, METAL_ID_VAL};
        ROUTE_LOW_OFS: nxt_rdata = route_low_ff;
        ROUTE_HIGH_OFS: nxt_rdata = route_high_ff;
        RESERVED_A_OFS: nxt_rdata = {30'h0, reserved_a_ff};
        RESERVED_B_OFS: nxt_rdata = {30'h0, reserved_b_ff};
        DEBUG_ORIGIN_OFS: nxt_rdata = {27'h0, debug_origin_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Registered answer, one cycle after the strobe
  // Read data holds between reads, so a late sample still sees it
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      CFG_RDATA <= 32'h0000_0000;
      CFG_ACK <= 1'b0;
    end else begin
      CFG_ACK <= CFG_RD || CFG_WR;
      if (CFG_RD) begin
        CFG_RDATA <= nxt_rdata;
      end
    end
  end

endmodule : switch_node_config_regs

//--- node_cfg_pkg.sv
// Package for the switch node configuration bank: offsets, field layout,
// reset values and shared types. Assumes 8-bit register numbers, 32-bit data.
package node_cfg_pkg;

  // ************************************************************
  // Register numbers
  // ************************************************************
  localparam logic [7:0] SWITCH_CONFIG_OFS = 8'h04;
  localparam logic [7:0] NODE_ID_OFS = 8'h05;
  localparam logic [7:0] CLOCK_MULT_OFS = 8'h06;
  localparam logic [7:0] SWITCH_CLK_DIV_OFS = 8'h07;
  localparam logic [7:0] REF_CLK_DIV_OFS = 8'h08;
  localparam logic [7:0] SCAN_IDENTITY_OFS = 8'h09;
  localparam logic [7:0] USER_CODE_OFS = 8'h0A;
  localparam logic [7:0] ROUTE_LOW_OFS = 8'h0C;
  localparam logic [7:0] ROUTE_HIGH_OFS = 8'h0D;
  localparam logic [7:0] RESERVED_A_OFS = 8'h10;
  localparam logic [7:0] RESERVED_B_OFS = 8'h11;
  localparam logic [7:0] DEBUG_ORIGIN_OFS = 8'h1F;
  localparam logic [7:0] LINK_BASE_OFS = 8'h20;
  localparam int NUM_LINKS = 8;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CM_NO_RESET_BIT = 31;
  localparam int CM_NO_WAIT_BIT = 30;
  localparam int CM_BYPASS_BIT = 29;
  localparam int CM_JTAG_BOOT_BIT = 28;
  localparam logic [31:0] CM_WRITE_MASK = 32'hF39F_FF7F;
  localparam int SW_CFG_MULT_LOCK_BIT = 8;
  localparam logic [31:0] SW_CFG_MASK = 32'h8000_0101;
  localparam logic [31:0] LOW16_MASK = 32'h0000_FFFF;
  localparam logic [31:0] TWO_BIT_MASK = 32'h0000_0003;
  localparam logic [31:0] DEBUG_MASK = 32'h0000_0013;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [31:0] CLOCK_MULT_RST = 32'h0000_0000;
  localparam logic [15:0] SWITCH_CLK_DIV_RST = 16'h0000;
  localparam logic [15:0] REF_CLK_DIV_RST = 16'h0003;

  // Arbitrary neutral identity values
  localparam logic [31:0] SCAN_IDENTITY_VAL = 32'h0000_1001;
  localparam logic [17:0] METAL_ID_VAL = 18'h0_0001;

  typedef enum logic [1:0] {
    TGT_SWITCH_SIDE_LINK,
    TGT_PROCESSOR_SIDE_LINK,
    TGT_SWITCH_CONTROL_BLOCK,
    TGT_UNDEFINED
  } target_kind_type;

  // Live state of one link, reported by the router
  typedef struct packed {
    target_kind_type attached_target_kind;
    logic [7:0] dest_link;
    logic junk;
    logic dest_busy;
    logic src_busy;
  } link_state_type;

  // Settings handed to the clock multiplier
  typedef struct packed {
    logic bypass;
    logic jtag_boot;
    logic no_wait;
    logic [2:0] p_div;
    logic [12:0] m_mul;
    logic [6:0] n_div;
  } mult_cfg_type;

endpackage : node_cfg_pkg

//--- route_select.sv
// Routing direction lookup from destination id against node id.
// Assumes combinational use inside the register bank.
`timescale 1ns/100ps
module route_select (
  // Tables and identifiers
  input wire logic [63:0] directions,
  input wire logic [15:0] node_id,
  input wire logic [15:0] dest_id,
  // Result
  output logic [3:0] direction,
  output logic mismatch
);
  logic [15:0] diff;

  always_comb begin
    diff = node_id ^ dest_id;
    direction = 4'h0;
    mismatch = |diff;
    for (int k = 0; k < 16; k++) begin
      if (diff[k]) begin
        direction = directions[4 * k +: 4];
      end
    end
  end
endmodule : route_select

//--- clock_divider.sv
// Programmable enable divider: one pulse every (ratio + 1) clock cycles.
// Assumes ratio may change at any time; the count carries on and wraps once it reaches or passes the new ratio.
`timescale 1ns/100ps
module clock_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic [15:0] ratio,
  // Output
  output logic tick
);
  logic [15:0] count_ff;

  always_ff @(posedge clk) begin
    if (!rst_n || count_ff >= ratio) begin
      count_ff <= 16'h0000;
    end else begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= (count_ff >= ratio);
    end
  end
endmodule : clock_divider

//--- node_cfg_chk.sv
// Checker for the node configuration bank, bound to its top module.
// Assumes single strobes; it shadows the settings written over the bus.
`timescale 1ns/100ps
module node_cfg_chk
  import node_cfg_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Access
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [31:0] CFG_WDATA,
  input wire logic [31:0] CFG_RDATA,
  // Watched outputs
  input wire logic [15:0] DEST_ID,
  input wire logic ROUTE_MISMATCH,
  input wire node_cfg_pkg::mult_cfg_type MULT_CFG,
  input wire logic TILE_RESET,
  input wire logic REF_CLK_EN,
  input wire logic [NUM_LINKS*4-1:0] LINK_DIRECTION,
  input wire logic [NUM_LINKS*2-1:0] LINK_NETWORK
);
  logic lock_ff;
  logic [15:0] node_ff;
  logic [NUM_LINKS*4-1:0] dir_ff;
  logic [NUM_LINKS*2-1:0] net_ff;
  mult_cfg_type wd_cfg;
  logic mult_wr;
  logic rst_due;

  assign wd_cfg = {CFG_WDATA[29:28], CFG_WDATA[30], CFG_WDATA[25:23], CFG_WDATA[20:8],
    CFG_WDATA[6:0]};
  assign mult_wr = CFG_WR && CFG_ADDR == CLOCK_MULT_OFS;
  assign rst_due = mult_wr && !CFG_WDATA[CM_NO_RESET_BIT] && !lock_ff;

  // Shadow of written settings, updated on the same edge as the bank
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      lock_ff <= 1'b0;
      node_ff <= 16'h0000;
      dir_ff <= '0;
      net_ff <= '0;
    end else if (CFG_WR) begin
      if (CFG_ADDR == SWITCH_CONFIG_OFS) lock_ff <= CFG_WDATA[SW_CFG_MULT_LOCK_BIT];
      if (CFG_ADDR == NODE_ID_OFS) node_ff <= CFG_WDATA[15:0];
      if (CFG_ADDR[7:3] == 5'h04) begin
        dir_ff[CFG_ADDR[2:0]*4 +: 4] <= CFG_WDATA[11:8];
        net_ff[CFG_ADDR[2:0]*2 +: 2] <= CFG_WDATA[5:4];
      end
    end
  end

  // ********
  // Properties
  // ********
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_tile_reset_cause: assert property (
    $past(RST_N) |-> TILE_RESET == $past(rst_due)) else $error("tile reset wrong");
  a_mult_fields_applied: assert property (
    mult_wr && !lock_ff |-> ##2 MULT_CFG == $past(wd_cfg, 2)) else $error("settings wrong");
  a_locked_mult_kept: assert property (
    mult_wr && lock_ff |=> $stable(MULT_CFG) [*2]) else $error("locked settings moved");
  a_route_mismatch: assert property (
    $past(RST_N) |-> ROUTE_MISMATCH == ($past(DEST_ID) != $past(node_ff)))
    else $error("mismatch flag wrong");
  a_link_settings: assert property (
    $past(RST_N) && $past(RST_N, 2) |-> LINK_DIRECTION == $past(dir_ff)
      && LINK_NETWORK == $past(net_ff)) else $error("link settings wrong");
  a_unmapped_zero: assert property (
    CFG_RD && (CFG_ADDR == 8'h0B || CFG_ADDR == 8'h28) |=> CFG_RDATA == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_scan_identity: assert property (
    CFG_RD && CFG_ADDR == SCAN_IDENTITY_OFS |=> CFG_RDATA == SCAN_IDENTITY_VAL)
    else $error("identity word wrong");
  // Holds only while the reference divider keeps its reset ratio
  a_ref_period: assert property (
    REF_CLK_EN |=> !REF_CLK_EN [*3] ##1 REF_CLK_EN) else $error("reference tick spacing");
endmodule : node_cfg_chk

bind switch_node_config_regs node_cfg_chk u_node_cfg_chk (
  .MCLK(MCLK), .RST_N(RST_N), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_ADDR(CFG_ADDR),
  .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA), .DEST_ID(DEST_ID),
  .ROUTE_MISMATCH(ROUTE_MISMATCH), .MULT_CFG(MULT_CFG), .TILE_RESET(TILE_RESET),
  .REF_CLK_EN(REF_CLK_EN), .LINK_DIRECTION(LINK_DIRECTION), .LINK_NETWORK(LINK_NETWORK)
);

//--- tile_cfg_model.sv
// Model of a processor tile issuing configuration reads and writes.
// Assumes the bank answers with a one-cycle acknowledge.
`timescale 1ns/100ps
module tile_cfg_model (
  // Clock
  input wire logic clk,
  // Configuration access
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_addr,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_ack,
  // Debug events of the two tiles
  output logic dbg0,
  output logic dbg1
);
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h0000_0000;
    dbg0 = 1'b0;
    dbg1 = 1'b0;
  end

  // One strobe per access; idle address and data are inverted so stale
  // values cannot pass for live ones
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
    int n;
    @(posedge clk);
    #1;
    cfg_wr = wr;
    cfg_rd = !wr;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge clk);
    #1;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = ~a;
    cfg_wdata = ~d;
    n = 0;
    while (cfg_ack !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    ok = (cfg_ack === 1'b1);
    q = cfg_rdata;
  endtask : access

  task automatic debug_pulse(input logic [1:0] src);
    @(posedge clk);
    #1;
    dbg0 = src[0];
    dbg1 = src[1];
    @(posedge clk);
    #1;
    dbg0 = 1'b0;
    dbg1 = 1'b0;
  endtask : debug_pulse
endmodule : tile_cfg_model

//--- switch_node_config_regs_tb.sv
// Testbench for the node configuration bank.
// Assumes the tile model carries all configuration traffic.
`timescale 1ns/100ps
module switch_node_config_regs_tb;
  import node_cfg_pkg::*;
  logic mclk, rst_n, cfg_wr, cfg_rd, cfg_ack, dbg0, dbg1, route_mis, tile_reset;
  logic sw_en, ref_en;
  logic [7:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [13:0] otp;
  link_state_type [NUM_LINKS-1:0] link_state;
  logic [15:0] dest_id;
  logic [3:0] route_dir;
  mult_cfg_type mult_cfg;
  logic [NUM_LINKS*4-1:0] link_dir;
  logic [NUM_LINKS*2-1:0] link_net;
  int failures = 0;
  int tests_run = 0;
  logic [31:0] mv [4] = '{32'h0B12_3456, 32'hA000_0000, 32'h5000_0000, 32'hFFFF_FFFF};

  switch_node_config_regs u_switch_node_config_regs (
    .MCLK(mclk), .RST_N(rst_n), .CFG_WR(cfg_wr), .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr),
    .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .CFG_ACK(cfg_ack), .OTP_USER_CODE(otp),
    .DEBUG_EVENT_TILE0(dbg0), .DEBUG_EVENT_TILE1(dbg1), .LINK_STATE(link_state),
    .DEST_ID(dest_id), .ROUTE_DIRECTION(route_dir), .ROUTE_MISMATCH(route_mis),
    .MULT_CFG(mult_cfg), .TILE_RESET(tile_reset), .SWITCH_CLK_EN(sw_en),
    .REF_CLK_EN(ref_en), .LINK_DIRECTION(link_dir), .LINK_NETWORK(link_net));

  tile_cfg_model u_tile_cfg_model (
    .clk(mclk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
    .dbg0(dbg0), .dbg1(dbg1));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic wrap_up();
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] exp);
    logic [31:0] q;
    logic ok;
    u_tile_cfg_model.access(wr, a, d, q, ok);
    if (!ok) begin
      failures++;
      $display("[ERR] ack at %h expected 1 seen 0", a);
      wrap_up();
    end else if (!wr) begin
      chk($sformatf("reg %h", a), exp, q);
    end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0000_0000);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000, exp);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  function automatic logic [31:0] mexp(input logic [31:0] v);
    return {6'h00, v[29:28], v[30], v[25:23], v[20:8], v[6:0]};
  endfunction : mexp

  initial begin
    int n;
    rst_n = 1'b0;
    dest_id = 16'h0000;
    link_state = '0;
    otp = 14'h2A5B;
    tick(16);
    rst_n = 1'b1;
    rd(NODE_ID_OFS, 32'h0000_0000);
    rd(SWITCH_CLK_DIV_OFS, 32'h0000_0000);
    rd(REF_CLK_DIV_OFS, 32'h0000_0003);
    rd(ROUTE_LOW_OFS, 32'h0000_0000);
    rd(ROUTE_HIGH_OFS, 32'h0000_0000);
    wr(USER_CODE_OFS, 32'hFFFF_FFFF);
    rd(USER_CODE_OFS, {otp, METAL_ID_VAL});
    rd(SCAN_IDENTITY_OFS, SCAN_IDENTITY_VAL);
    // No-wait is paired both with zero fields and with every field at its maximum here
    foreach (mv[i]) begin
      wr(CLOCK_MULT_OFS, mv[i]);
      chk("tile reset", {31'h0, !mv[i][31]}, {31'h0, tile_reset});
      tick(1);
      chk("mult cfg", mexp(mv[i]), {6'h00, mult_cfg});
      rd(CLOCK_MULT_OFS, mv[i] & CM_WRITE_MASK);
    end
    wr(SWITCH_CONFIG_OFS, 32'h0000_0100);
    wr(CLOCK_MULT_OFS, 32'h0000_0000);
    chk("locked reset", 32'h0000_0000, {31'h0, tile_reset});
    rd(CLOCK_MULT_OFS, CM_WRITE_MASK);
    wr(SWITCH_CONFIG_OFS, 32'hFFFF_FEFF);
    rd(SWITCH_CONFIG_OFS, 32'h8000_0001);
    wr(NODE_ID_OFS, 32'hFFFF_00A5);
    rd(NODE_ID_OFS, 32'h0000_00A5);
    wr(ROUTE_LOW_OFS, 32'h7654_3210);
    wr(ROUTE_HIGH_OFS, 32'hFEDC_BA98);
    // Bit 0 also differs, so only the top differing bit may win
    for (int k = 0; k < 16; k++) begin
      dest_id = 16'h00A5 ^ ((16'h0001 << k) | 16'h0001);
      tick(1);
      chk("route dir", 32'(k), {28'h0, route_dir});
    end
    dest_id = 16'h00A5;
    for (int i = 0; i < NUM_LINKS; i++) begin
      link_state[i] = {i[1:0], 8'(i + 16), i[2:0]};
      wr(LINK_BASE_OFS + 8'(i), {20'hF_FFFF, 4'(15 - i), 2'b11, 2'(3 - i), 4'hF});
      rd(LINK_BASE_OFS + 8'(i), {6'h00, i[1:0], 8'(i + 16), 4'h0, 4'(15 - i), 2'h0,
        2'(3 - i), 1'b0, i[2:0]});
    end
    rd(8'h28, 32'h0000_0000);
    rd(8'h0B, 32'h0000_0000);
    u_tile_cfg_model.debug_pulse(2'b01);
    rd(DEBUG_ORIGIN_OFS, 32'h0000_0001);
    u_tile_cfg_model.debug_pulse(2'b10);
    rd(DEBUG_ORIGIN_OFS, 32'h0000_0002);
    wr(RESERVED_A_OFS, 32'hFFFF_FFFF);
    rd(RESERVED_A_OFS, 32'h0000_0003);
    wr(REF_CLK_DIV_OFS, 32'hFFFF_0003);
    rd(REF_CLK_DIV_OFS, 32'h0000_0003);
    wr(SWITCH_CLK_DIV_OFS, 32'hFFFF_0002);
    rd(SWITCH_CLK_DIV_OFS, 32'h0000_0002);
    n = 0;
    repeat (30) begin
      tick(1);
      n += int'(sw_en === 1'b1);
    end
    chk("switch ticks", 32'd10, 32'(n));
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    rd(ROUTE_LOW_OFS, 32'h0000_0000);
    rd(SWITCH_CLK_DIV_OFS, 32'h0000_0000);
    wrap_up();
  end
endmodule : switch_node_config_regs_tb
